// file: core/osavf_filter.v
`timescale 1ns/100ps
`include "osavf_map.vh"
module osavf_filter #(
  parameter CH = `OSAVF_CHANNELS,
  parameter SW = `OSAVF_SAMPLE_W,
  parameter AW = `OSAVF_ACC_W,
  parameter GAP = `OSAVF_GAP_CYC
) (
  input  wire           mclk,
  input  wire           rst_b,
  input  wire           convertTriggerGroupA,
  input  wire           convertTriggerGroupB,
  input  wire [2:0]     averageRatioSelect,
  input  wire [CH*SW-1:0] sampleData,
  input  wire           sampleValid,
  output reg            sampleStrobe_reg,
  output reg  [CH*SW-1:0] resultData_reg,
  output reg            resultValid_reg,
  output reg            busy_reg,
  output reg            selectError_reg
);
  localparam IDLE = 2'b00;
  localparam WAIT = 2'b01;
  localparam GAPS = 2'b10;
  localparam DONE = 2'b11;
  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg [1:0] trigA_reg;
  reg [1:0] trigB_reg;
  reg       trigDly_reg;
  reg [2:0] selS1_reg;
  reg [2:0] selS2_reg;
  wire      trig;
  wire      trigRise;
  always @(posedge mclk) begin
    if (!rst_b) begin
      trigA_reg   <= 2'h0;
      trigB_reg   <= 2'h0;
      trigDly_reg <= 1'b0;
      selS1_reg   <= 3'h0;
      selS2_reg   <= 3'h0;
    end else begin
      trigA_reg   <= {trigA_reg[0], convertTriggerGroupA};
      trigB_reg   <= {trigB_reg[0], convertTriggerGroupB};
      trigDly_reg <= trig;
      selS1_reg   <= averageRatioSelect;
      selS2_reg   <= selS1_reg;
    end
  end
  assign trig     = trigA_reg[1] & trigB_reg[1];
  assign trigRise = trig & ~trigDly_reg;
  ////////////////////////////////////////////////////////////////
  // Ratio decode
  function [6:0] ratioOf;
    input [2:0] sel;
    begin
      ratioOf = (sel == `OSAVF_SEL_BAD) ? 7'h01 : (7'h01 << sel);
    end
  endfunction
  ////////////////////////////////////////////////////////////////
  // Sequencer
  reg [1:0]        state_reg;
  reg [1:0]        state_next;
  reg [2:0]        selHeld_reg;
  reg [6:0]        count_reg;
  reg [15:0]       gap_reg;
  reg              first_reg;
  wire [CH*SW-1:0] avgAll;
  wire [6:0]       ratio;
  wire             takeSample;
  wire             lastSample;
  wire             startOk;
  wire             startTaken;
  wire             gapDone;
  assign startOk    = trigRise && (selS2_reg != `OSAVF_SEL_BAD);
  assign startTaken = (state_reg == IDLE) && startOk;
  assign ratio      = ratioOf(selHeld_reg);
  // Returned samples only count while waiting
  assign takeSample = (state_reg == WAIT) && sampleValid;
  assign lastSample = takeSample && (count_reg == ratio - 7'h01);
  assign gapDone    = (gap_reg == 16'h0000);
  ////////////////////////////////////////////////////////////////
  // Next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      IDLE: begin
        if (startOk) begin
          state_next = WAIT;
        end
      end
      WAIT: begin
        if (takeSample) begin
          state_next = lastSample ? DONE : GAPS;
        end
      end
      GAPS: begin
        if (gapDone) begin
          state_next = WAIT;
        end
      end
      DONE: begin
        state_next = IDLE;
      end
      default: begin
        state_next = IDLE;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////
  // State and busy
  always @(posedge mclk) begin
    if (!rst_b) begin
      state_reg <= IDLE;
      busy_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy_reg  <= (state_next != IDLE);
    end
  end
  always @(posedge mclk) begin
    if (!rst_b) begin
      selectError_reg <= 1'b0;
    end else begin
      selectError_reg <= (selS2_reg == `OSAVF_SEL_BAD);
    end
  end
  ////////////////////////////////////////////////////////////////
  // Sequence bookkeeping
  always @(posedge mclk) begin
    if (!rst_b) begin
      selHeld_reg <= 3'h0;
      count_reg   <= 7'h00;
      first_reg   <= 1'b0;
    end else begin
      if (startTaken) begin
        selHeld_reg <= selS2_reg;
        count_reg   <= 7'h00;
        first_reg   <= 1'b1;
      end
      if (takeSample) begin
        first_reg <= 1'b0;
        count_reg <= count_reg + 7'h01;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  // Sampling strobe and spacing
  always @(posedge mclk) begin
    if (!rst_b) begin
      gap_reg          <= 16'h0000;
      sampleStrobe_reg <= 1'b0;
    end else begin
      sampleStrobe_reg <= 1'b0;
      if (startTaken) begin
        sampleStrobe_reg <= 1'b1;
      end
      // Spacing counts from the returned sample
      if (takeSample) begin
        gap_reg <= GAP[15:0] - `OSAVF_GAP_LEAD;
      end
      if (state_reg == GAPS) begin
        gap_reg <= gap_reg - 16'h0001;
        if (gapDone) begin
          sampleStrobe_reg <= 1'b1;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  // Result register
  // Taken one cycle after the last add, so it is included
  // One word per channel per sequence
  always @(posedge mclk) begin
    if (!rst_b) begin
      resultData_reg  <= {CH*SW{1'b0}};
      resultValid_reg <= 1'b0;
    end else begin
      resultValid_reg <= 1'b0;
      if (state_reg == DONE) begin
        resultData_reg  <= avgAll;
        resultValid_reg <= 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  // Per-channel accumulators
  // Shift by select code divides by the ratio
  genvar i;
  generate
    for (i = 0; i < CH; i = i + 1) begin : gAcc
      osavf_accum #(
        .SW (SW),
        .AW (AW)
      ) uAcc (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .clear   (first_reg),
        .add     (takeSample),
        .sample  (sampleData[i*SW +: SW]),
        .shift   (selHeld_reg),
        .sum_reg (),
        .avg     (avgAll[i*SW +: SW])
      );
    end
  endgenerate
endmodule // osavf_filter

// file: common/osavf_map.vh
`ifndef OSAVF_MAP_VH
`define OSAVF_MAP_VH
// Ratio select codes
`define OSAVF_SEL_OFF      3'h0
`define OSAVF_SEL_MAX      3'h6
`define OSAVF_SEL_BAD      3'h7
// Sample and channel geometry
`define OSAVF_SAMPLE_W     18
`define OSAVF_CHANNELS     8
`define OSAVF_ACC_W        24
// Internal sampling strobe spacing, ns, derived from 500 kSPS
`define OSAVF_SAMPLE_NS    2000
`define OSAVF_CLK_NS       100
`define OSAVF_GAP_CYC      (`OSAVF_SAMPLE_NS / `OSAVF_CLK_NS)
// Gap load offset: load and zero cycles of the spacing count
`define OSAVF_GAP_LEAD     16'h0002
`endif

// file: core/osavf_accum.v
`timescale 1ns/100ps
`include "osavf_map.vh"
// One channel accumulator
module osavf_accum #(
  parameter SW = `OSAVF_SAMPLE_W,
  parameter AW = `OSAVF_ACC_W
) (
  input  wire          mclk,
  input  wire          rst_b,
  input  wire          clear,
  input  wire          add,
  input  wire [SW-1:0] sample,
  input  wire [2:0]    shift,
  output reg  [AW-1:0] sum_reg,
  output wire [SW-1:0] avg
);
  wire signed [AW-1:0] ext;
  wire signed [AW-1:0] shifted;
  assign ext = {{(AW-SW){sample[SW-1]}}, sample};
  assign shifted = $signed(sum_reg) >>> shift;
  assign avg = shifted[SW-1:0];
  always @(posedge mclk) begin
    if (!rst_b) begin
      sum_reg <= {AW{1'b0}};
    end else if (clear) begin
      sum_reg <= add ? ext : {AW{1'b0}};
    end else if (add) begin
      sum_reg <= sum_reg + ext;
    end
  end
endmodule // osavf_accum

// file: sim/osavf_filter_monitor.sv
`timescale 1ns/100ps
module osavf_filter_monitor (
  input logic         mclk,
  input logic         rst_b,
  input logic         convertTriggerGroupA,
  input logic         convertTriggerGroupB,
  input logic         sampleStrobe_reg,
  input logic [143:0] resultData_reg,
  input logic         resultValid_reg,
  input logic         busy_reg,
  input logic         selectError_reg
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  bad_sel_idle_a: assert property ($rose(busy_reg) |-> !selectError_reg)
    else $error("start taken on bad select");
  busy_end_a: assert property ($fell(busy_reg) |-> resultValid_reg)
    else $error("sequence ended without result");
  start_strobe_a: assert property ($rose(busy_reg) |-> sampleStrobe_reg)
    else $error("no first strobe");
  trig_start_a: assert property ($rose(convertTriggerGroupA && convertTriggerGroupB) && !busy_reg
    && !selectError_reg |-> ##[1:5] busy_reg) else $error("trigger not taken");
  strobe_busy_a: assert property (sampleStrobe_reg |-> busy_reg)
    else $error("strobe outside sequence");
  strobe_gap_a: assert property (sampleStrobe_reg |=> !sampleStrobe_reg [*3])
    else $error("strobes too close");
  one_word_a: assert property (resultValid_reg |=> !resultValid_reg)
    else $error("result longer than one cycle");
  data_hold_a: assert property ($past(rst_b) && !resultValid_reg |-> $stable(resultData_reg))
    else $error("result changed between words");
  done_idle_a: assert property (resultValid_reg |-> ##[0:1] !busy_reg)
    else $error("sequence runs on after result");
endmodule // osavf_filter_monitor
bind osavf_filter osavf_filter_monitor u_osavf_filter_monitor (
  .mclk                 (mclk),
  .rst_b                (rst_b),
  .convertTriggerGroupA (convertTriggerGroupA),
  .convertTriggerGroupB (convertTriggerGroupB),
  .sampleStrobe_reg     (sampleStrobe_reg),
  .resultData_reg       (resultData_reg),
  .resultValid_reg      (resultValid_reg),
  .busy_reg             (busy_reg),
  .selectError_reg      (selectError_reg)
);

// file: sim/osavf_conv_model.sv
`timescale 1ns/100ps
module osavf_conv_model (
  input  wire          mclk,
  input  wire          sampleStrobe,
  input  wire          busy,
  output logic         sampleValid = 1'b0,
  output logic [143:0] sampleData = '0
);
  logic [2:0]  dlyReg = 3'h0;
  logic [17:0] kReg = 18'h1;
  always @(posedge mclk) begin
    dlyReg <= {dlyReg[1:0], sampleStrobe};
    sampleValid <= dlyReg[2];
    if (dlyReg[2]) begin
      for (int i = 0; i < 8; i++) sampleData[i*18+:18] <= i[0] ? -kReg : kReg;
      kReg <= kReg + 18'h1;
    end else sampleData <= ~sampleData;
    if (!busy && !sampleStrobe) kReg <= 18'h1;
  end
endmodule // osavf_conv_model

// file: sim/osavf_filter_tb.sv
`timescale 1ns/100ps
module osavf_filter_tb;
  logic         mclk = 0;
  logic         rst_b = 0;
  logic         trig = 0;
  logic [2:0]   sel = 3'h0;
  logic [143:0] sData, rData;
  logic         sValid, strobe, rValid, busy, selErr;
  int           miscompares = 0;
  int           cmp_count = 0;
  int           cycles = 0;
  initial forever #50 mclk = ~mclk;
  osavf_filter #(.GAP(4)) u_osavf_filter (.mclk(mclk), .rst_b(rst_b), .convertTriggerGroupA(trig),
    .convertTriggerGroupB(trig), .averageRatioSelect(sel), .sampleData(sData), .sampleValid(sValid),
    .sampleStrobe_reg(strobe), .resultData_reg(rData), .resultValid_reg(rValid), .busy_reg(busy),
    .selectError_reg(selErr));
  osavf_conv_model u_osavf_conv_model (.mclk(mclk), .sampleStrobe(strobe), .busy(busy),
    .sampleValid(sValid), .sampleData(sData));
  ////////////////////////////////////////
  task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Select s, switch to s2 mid-run, expect ratio n
  task automatic run_seq(input logic [2:0] s, input logic [2:0] s2, input int n);
    int w = 0;
    sel <= s;
    repeat (4) @(posedge mclk);
    trig <= 1'b1;
    repeat (6) @(posedge mclk);
    sel <= s2;
    trig <= 1'b0;
    #1;
    while (rValid !== 1'b1 && w < 1000) begin
      @(posedge mclk);
      #1;
      w++;
    end
    if (w >= 1000) begin
      miscompares++;
      $display("[ERR] result wait expected below 1000 seen %0d", w);
    end
    for (int i = 0; i < 8; i++)
      check("result", i[0] ? 18'(-((n + 2) / 2)) : 18'((n + 1) / 2), rData[i*18+:18]);
    @(posedge mclk);
    $display("sequence ratio %0d done", n);
  endtask
  task automatic test_bad_sel;
    int hits = 0;
    sel <= 3'h7;
    repeat (5) @(posedge mclk);
    trig <= 1'b1;
    repeat (20) begin
      @(posedge mclk);
      #1;
      if (busy !== 1'b0 || strobe !== 1'b0) hits++;
    end
    check("selErr", 18'h1, {17'h0, selErr});
    check("busy", 18'h0, 18'(hits));
    @(posedge mclk);
    trig <= 1'b0;
    sel <= 3'h0;
    $display("bad select done");
  endtask
  ////////////////////////////////////////
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      $display("[ERR] cycles expected below 5000 seen %0d", cycles);
      report_and_stop();
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    for (int s = 0; s < 7; s++) run_seq(3'(s), 3'(s), 1 << s);
    run_seq(3'h2, 3'h1, 4);
    test_bad_sel();
    report_and_stop();
  end
endmodule // osavf_filter_tb
